// [core/mst_stream_attr_regs.sv]
// Our own choice: the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
module mst_stream_attr_regs (
	input  wire logic        mclk,              // System clock, 40 MHz
	input  wire logic        nrst,              // Asynchronous reset, active low
	// Register port
	input  wire logic [11:0] regAddr,           // Byte address
	input  wire logic [31:0] regWdata,          // Write data, discarded
	input  wire logic        regWr,             // Write strobe, used only to refuse a read in the same cycle
	input  wire logic        regRd,             // Read strobe
	output logic      [31:0] regRdata,          // Read data, cycle after strobe
	// Stream 2 decoded attributes
	input  wire logic        s2AttrValid,       // One-cycle capture strobe
	input  wire logic [14:0] s2VsyncWidth,      // Vsync width, lines
	input  wire logic [15:0] s2VsyncToActive,   // Vsync edge to active, lines
	input  wire logic [15:0] s2TotalLines,      // Lines per frame
	input  wire logic [7:0]  s2FirstMisc,       // First misc attribute byte
	input  wire logic [7:0]  s2SecondMisc,      // Second misc attribute byte
	input  wire logic [23:0] s2ClockRecM,       // Clock recovery M
	input  wire logic [23:0] s2ClockRecN,       // Clock recovery N
	input  wire logic        s2BlankIdValid,    // One-cycle identifier strobe
	input  wire logic [7:0]  s2BlankIdByte,     // Blanking identifier byte
	// Stream 3 decoded attributes
	input  wire logic        s3AttrValid,       // One-cycle capture strobe
	input  wire logic [15:0] s3ActivePixels,    // Active pixels per line
	input  wire logic        s3HsyncPolarity,   // Requested hsync polarity
	input  wire logic [14:0] s3HsyncWidth,      // Hsync width, video clocks
	input  wire logic [15:0] s3HsyncToActive,   // Hsync edge to active, clocks
	input  wire logic [15:0] s3LineTotalClocks, // Video clocks per line
	input  wire logic [15:0] s3ActiveLines,     // Active lines per frame
	input  wire logic        s3VsyncPolarity,   // 1 active-high vsync
	input  wire logic [14:0] s3VsyncWidth,      // Vsync width, lines
	input  wire logic [15:0] s3VsyncToActive,   // Vsync edge to active, lines
	input  wire logic [15:0] s3TotalLines       // Lines per frame
);

	// Zero-extend a 16-bit field to a bus word
	function automatic logic [31:0] ext16(input logic [15:0] v);
		ext16 = {16'h0000, v};
	endfunction

	// Zero-extend a 24-bit field to a bus word
	function automatic logic [31:0] ext24(input logic [23:0] v);
		ext24 = {8'h00, v};
	endfunction

	// Zero-extend a 15-bit sync width to a bus word
	function automatic logic [31:0] ext15(input logic [14:0] v);
		ext15 = {17'h00000, v};
	endfunction

	// Zero-extend an attribute byte to a bus word
	function automatic logic [31:0] ext8(input logic [7:0] v);
		ext8 = {24'h000000, v};
	endfunction

	// Zero-extend a polarity flag to a bus word
	function automatic logic [31:0] ext1(input logic v);
		ext1 = {31'h00000000, v};
	endfunction

	// Second misc byte with its reserved field forced low
	function automatic logic [7:0] cleanSecondMisc(input logic [7:0] v);
		cleanSecondMisc = {v[mst_attr_pkg::SI_STD_BIT],
			4'h0,
			v[mst_attr_pkg::SI_STEREO_HI:mst_attr_pkg::SI_STEREO_LO],
			v[mst_attr_pkg::SI_EVEN]};
	endfunction

	// Stream 2 stored attributes
	logic [14:0] s2VsyncWidth_r;
	logic [15:0] s2VsyncToActive_r;
	logic [15:0] s2TotalLines_r;
	logic [7:0]  s2FormatAttrs_r;
	logic [7:0]  s2StereoInterlace_r;
	logic [23:0] s2ClockRecM_r;
	logic [23:0] s2ClockRecN_r;
	logic [7:0]  s2BlankIdByte_r;

	// Stream 3 stored attributes
	logic [15:0] s3ActivePixels_r;
	logic        s3HsyncPolarity_r;
	logic [14:0] s3HsyncWidth_r;
	logic [15:0] s3HsyncToActive_r;
	logic [15:0] s3LineTotalClocks_r;
	logic [15:0] s3ActiveLines_r;
	logic        s3VsyncPolarity_r;
	logic [14:0] s3VsyncWidth_r;
	logic [15:0] s3VsyncToActive_r;
	logic [15:0] s3TotalLines_r;

	// Read path
	logic [31:0] regRdata_r;
	logic [31:0] regRdata_nxt;

	// Cleaned at capture so a read never has to mask the reserved field
	logic [7:0] s2SecondMiscClean;
	assign s2SecondMiscClean = cleanSecondMisc(s2SecondMisc);

	// A read colliding with a write is refused, so the bus sees zero
	logic rdTaken;
	assign rdTaken = regRd && !regWr;

	// Stream 2 vsync width; own strobe so stream 3 never disturbs it
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			s2VsyncWidth_r <= mst_attr_pkg::ATTR_RESET[14:0];
		end else if (s2AttrValid) begin
			s2VsyncWidth_r <= s2VsyncWidth;
		end
	end

	// Stream 2 vsync edge to first active line
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			s2VsyncToActive_r <= mst_attr_pkg::ATTR_RESET[15:0];
		end else if (s2AttrValid) begin
			s2VsyncToActive_r <= s2VsyncToActive;
		end
	end

	// Stream 2 lines per frame
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			s2TotalLines_r <= mst_attr_pkg::ATTR_RESET[15:0];
		end else if (s2AttrValid) begin
			s2TotalLines_r <= s2TotalLines;
		end
	end

	// Stream 2 first misc byte, kept verbatim so reserved codes pass through
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			s2FormatAttrs_r <= mst_attr_pkg::ATTR_RESET[7:0];
		end else if (s2AttrValid) begin
			s2FormatAttrs_r <= s2FirstMisc;
		end
	end

	// Stream 2 second misc byte, reserved field already cleaned
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			s2StereoInterlace_r <= mst_attr_pkg::ATTR_RESET[7:0];
		end else if (s2AttrValid) begin
			s2StereoInterlace_r <= s2SecondMiscClean;
		end
	end

	// Stream 2 clock recovery M
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			s2ClockRecM_r <= mst_attr_pkg::ATTR_RESET[23:0];
		end else if (s2AttrValid) begin
			s2ClockRecM_r <= s2ClockRecM;
		end
	end

	// Stream 2 clock recovery N, same strobe as M so the pair never tears
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			s2ClockRecN_r <= mst_attr_pkg::ATTR_RESET[23:0];
		end else if (s2AttrValid) begin
			s2ClockRecN_r <= s2ClockRecN;
		end
	end

	// Blanking identifier arrives once per blanking period, apart from the frame set
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			s2BlankIdByte_r <= mst_attr_pkg::ATTR_RESET[7:0];
		end else if (s2BlankIdValid) begin
			s2BlankIdByte_r <= s2BlankIdByte;
		end
	end

	// Stream 3 active pixels per line
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			s3ActivePixels_r <= mst_attr_pkg::ATTR_RESET[15:0];
		end else if (s3AttrValid) begin
			s3ActivePixels_r <= s3ActivePixels;
		end
	end

	// Stream 3 hsync polarity
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			s3HsyncPolarity_r <= mst_attr_pkg::ATTR_RESET[0];
		end else if (s3AttrValid) begin
			s3HsyncPolarity_r <= s3HsyncPolarity;
		end
	end

	// Stream 3 hsync width
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			s3HsyncWidth_r <= mst_attr_pkg::ATTR_RESET[14:0];
		end else if (s3AttrValid) begin
			s3HsyncWidth_r <= s3HsyncWidth;
		end
	end

	// Stream 3 hsync edge to first active clock
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			s3HsyncToActive_r <= mst_attr_pkg::ATTR_RESET[15:0];
		end else if (s3AttrValid) begin
			s3HsyncToActive_r <= s3HsyncToActive;
		end
	end

	// Stream 3 video clocks per line
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			s3LineTotalClocks_r <= mst_attr_pkg::ATTR_RESET[15:0];
		end else if (s3AttrValid) begin
			s3LineTotalClocks_r <= s3LineTotalClocks;
		end
	end

	// Stream 3 active lines per frame
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			s3ActiveLines_r <= mst_attr_pkg::ATTR_RESET[15:0];
		end else if (s3AttrValid) begin
			s3ActiveLines_r <= s3ActiveLines;
		end
	end

	// Stream 3 vsync polarity
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			s3VsyncPolarity_r <= mst_attr_pkg::ATTR_RESET[0];
		end else if (s3AttrValid) begin
			s3VsyncPolarity_r <= s3VsyncPolarity;
		end
	end

	// Stream 3 vsync width
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			s3VsyncWidth_r <= mst_attr_pkg::ATTR_RESET[14:0];
		end else if (s3AttrValid) begin
			s3VsyncWidth_r <= s3VsyncWidth;
		end
	end

	// Stream 3 vsync edge to first active line
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			s3VsyncToActive_r <= mst_attr_pkg::ATTR_RESET[15:0];
		end else if (s3AttrValid) begin
			s3VsyncToActive_r <= s3VsyncToActive;
		end
	end

	// Stream 3 lines per frame
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			s3TotalLines_r <= mst_attr_pkg::ATTR_RESET[15:0];
		end else if (s3AttrValid) begin
			s3TotalLines_r <= s3TotalLines;
		end
	end

	// Read decode; unused high bits are zero-filled by the width of each field
	always_comb begin
		case (regAddr)
			mst_attr_pkg::S2_VSYNC_WIDTH_OFS: begin
				regRdata_nxt = ext15(s2VsyncWidth_r);
			end
			mst_attr_pkg::S2_VSYNC_TO_ACTIVE_LINES_OFS: begin
				regRdata_nxt = ext16(s2VsyncToActive_r);
			end
			mst_attr_pkg::S2_TOTAL_LINES_OFS: begin
				regRdata_nxt = ext16(s2TotalLines_r);
			end
			mst_attr_pkg::S2_FORMAT_ATTRS_OFS: begin
				regRdata_nxt = ext8(s2FormatAttrs_r);
			end
			mst_attr_pkg::S2_STEREO_INTERLACE_OFS: begin
				regRdata_nxt = ext8(s2StereoInterlace_r);
			end
			mst_attr_pkg::S2_CLOCK_RECOVERY_M_OFS: begin
				regRdata_nxt = ext24(s2ClockRecM_r);
			end
			mst_attr_pkg::S2_CLOCK_RECOVERY_N_OFS: begin
				regRdata_nxt = ext24(s2ClockRecN_r);
			end
			mst_attr_pkg::S2_BLANKING_ID_BYTE_OFS: begin
				regRdata_nxt = ext8(s2BlankIdByte_r);
			end
			mst_attr_pkg::S3_ACTIVE_PIXELS_OFS: begin
				regRdata_nxt = ext16(s3ActivePixels_r);
			end
			mst_attr_pkg::S3_HSYNC_POLARITY_OFS: begin
				regRdata_nxt = ext1(s3HsyncPolarity_r);
			end
			mst_attr_pkg::S3_HSYNC_WIDTH_OFS: begin
				regRdata_nxt = ext15(s3HsyncWidth_r);
			end
			mst_attr_pkg::S3_HSYNC_TO_ACTIVE_OFS: begin
				regRdata_nxt = ext16(s3HsyncToActive_r);
			end
			mst_attr_pkg::S3_LINE_TOTAL_CLOCKS_OFS: begin
				regRdata_nxt = ext16(s3LineTotalClocks_r);
			end
			mst_attr_pkg::S3_ACTIVE_LINES_OFS: begin
				regRdata_nxt = ext16(s3ActiveLines_r);
			end
			mst_attr_pkg::S3_VSYNC_POLARITY_OFS: begin
				regRdata_nxt = ext1(s3VsyncPolarity_r);
			end
			mst_attr_pkg::S3_VSYNC_WIDTH_OFS: begin
				regRdata_nxt = ext15(s3VsyncWidth_r);
			end
			mst_attr_pkg::S3_VSYNC_TO_ACTIVE_LINES_OFS: begin
				regRdata_nxt = ext16(s3VsyncToActive_r);
			end
			mst_attr_pkg::S3_TOTAL_LINES_OFS: begin
				regRdata_nxt = ext16(s3TotalLines_r);
			end
			default: begin
				regRdata_nxt = mst_attr_pkg::UNMAPPED_READ;
			end
		endcase
	end

	// Read data stands for exactly the cycle after a read strobe without a write strobe, zero otherwise.
	// Writes are never decoded: every register here is fed only by the link side.
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			regRdata_r <= mst_attr_pkg::UNMAPPED_READ;
		end else if (rdTaken) begin
			regRdata_r <= regRdata_nxt;
		end else begin
			regRdata_r <= mst_attr_pkg::UNMAPPED_READ;
		end
	end

	// Port comes straight from the read data flip-flop
	assign regRdata = regRdata_r;

	// Write data has no destination; folded here so it is visibly consumed
	logic wrUnused;
	assign wrUnused = &{1'b0, regWdata, regWr};

endmodule
`default_nettype wire

// [core/mst_attr_pkg.sv]
`default_nettype none
package mst_attr_pkg;

	// Register byte offsets, stream 2
	localparam logic [11:0] S2_VSYNC_WIDTH_OFS          = 12'h55c;
	localparam logic [11:0] S2_VSYNC_TO_ACTIVE_LINES_OFS = 12'h560;
	localparam logic [11:0] S2_TOTAL_LINES_OFS          = 12'h564;
	localparam logic [11:0] S2_FORMAT_ATTRS_OFS         = 12'h568;
	localparam logic [11:0] S2_STEREO_INTERLACE_OFS     = 12'h56c;
	localparam logic [11:0] S2_CLOCK_RECOVERY_M_OFS     = 12'h570;
	localparam logic [11:0] S2_CLOCK_RECOVERY_N_OFS     = 12'h574;
	localparam logic [11:0] S2_BLANKING_ID_BYTE_OFS     = 12'h578;

	// Register byte offsets, stream 3
	localparam logic [11:0] S3_ACTIVE_PIXELS_OFS        = 12'h580;
	localparam logic [11:0] S3_HSYNC_POLARITY_OFS       = 12'h584;
	localparam logic [11:0] S3_HSYNC_WIDTH_OFS          = 12'h588;
	localparam logic [11:0] S3_HSYNC_TO_ACTIVE_OFS      = 12'h58c;
	localparam logic [11:0] S3_LINE_TOTAL_CLOCKS_OFS    = 12'h590;
	localparam logic [11:0] S3_ACTIVE_LINES_OFS         = 12'h594;
	localparam logic [11:0] S3_VSYNC_POLARITY_OFS       = 12'h598;
	localparam logic [11:0] S3_VSYNC_WIDTH_OFS          = 12'h59c;
	localparam logic [11:0] S3_VSYNC_TO_ACTIVE_LINES_OFS = 12'h5a0;
	localparam logic [11:0] S3_TOTAL_LINES_OFS          = 12'h5a4;

	// Field widths
	localparam int SYNC_WIDTH_W = 15;
	localparam int COUNT_W      = 16;
	localparam int MISC_W       = 8;
	localparam int CLK_REC_W    = 24;
	localparam int BLANK_ID_W   = 8;

	// First misc attribute byte layout
	localparam int FMT_DEPTH_HI   = 7;
	localparam int FMT_DEPTH_LO   = 5;
	localparam int FMT_COLORIM    = 4;
	localparam int FMT_QUANT      = 3;
	localparam int FMT_COMP_HI    = 2;
	localparam int FMT_COMP_LO    = 1;
	localparam int FMT_CLOCK_MODE = 0;

	// Second misc attribute byte layout
	localparam int SI_STD_BIT   = 7;
	localparam int SI_RSVD_HI   = 6;
	localparam int SI_RSVD_LO   = 3;
	localparam int SI_STEREO_HI = 2;
	localparam int SI_STEREO_LO = 1;
	localparam int SI_EVEN      = 0;

	// Component format codes
	typedef enum logic [1:0] {
		COMP_RGB    = 2'b00,
		COMP_YC422  = 2'b01,
		COMP_YC444  = 2'b10,
		COMP_RSVD   = 2'b11
	} comp_format_t;

	// Reset values of every attribute register
	localparam logic [31:0] ATTR_RESET = 32'h0000_0000;
	// Answer to an unmapped read
	localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

endpackage
`default_nettype wire

// [tb/mst_stream_attr_regs_props.sv]
`timescale 1ns/100ps
`default_nettype none
module mst_stream_attr_regs_props (
	input wire logic        mclk,           // Clock
	input wire logic        nrst,           // Reset, low
	input wire logic [11:0] regAddr,        // Address
	input wire logic        regRd,          // Read strobe
	input wire logic [31:0] regRdata,       // Read data
	input wire logic        s2AttrValid,    // S2 strobe
	input wire logic [15:0] s2TotalLines,   // S2 lines
	input wire logic [7:0]  s2FirstMisc,    // S2 misc
	input wire logic [23:0] s2ClockRecM,    // S2 M
	input wire logic        s2BlankIdValid, // Id strobe
	input wire logic [7:0]  s2BlankIdByte,  // Id byte
	input wire logic        s3AttrValid,    // S3 strobe
	input wire logic [15:0] s3ActivePixels  // S3 pixels
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!nrst);
	// Quiet bus between reads, so a stale word is never taken as an answer
	idle_data_zero_a: assert property (!regRd |=> regRdata == 32'h0)
		else $error("read data not zero outside a read");
	misc_rsvd_zero_a: assert property (regRd && regAddr == 12'h56c |=>
		{regRdata[31:8], regRdata[6:3]} == 28'h0) else $error("reserved misc bits set");
	vsw_upper_zero_a: assert property (regRd && regAddr == 12'h55c |=>
		regRdata[31:15] == 17'h0) else $error("vsync width upper bits set");
	// A read one cycle after a capture must already see the new word
	pixels_capture_a: assert property (s3AttrValid ##1 (regRd && regAddr == 12'h580
		&& !s3AttrValid) |=> regRdata == {16'h0, $past(s3ActivePixels, 2)})
		else $error("active pixels not captured");
	total_capture_a: assert property (s2AttrValid ##1 (regRd && regAddr == 12'h564
		&& !s2AttrValid) |=> regRdata == {16'h0, $past(s2TotalLines, 2)})
		else $error("total lines not captured");
	first_misc_a: assert property (s2AttrValid ##1 (regRd && regAddr == 12'h568
		&& !s2AttrValid) |=> regRdata == {24'h0, $past(s2FirstMisc, 2)})
		else $error("first misc byte not captured");
	clock_m_a: assert property (s2AttrValid ##1 (regRd && regAddr == 12'h570
		&& !s2AttrValid) |=> regRdata == {8'h0, $past(s2ClockRecM, 2)})
		else $error("clock recovery M not captured");
	blank_id_a: assert property (s2BlankIdValid ##1 (regRd && regAddr == 12'h578
		&& !s2BlankIdValid) |=> regRdata == {24'h0, $past(s2BlankIdByte, 2)})
		else $error("blanking id not captured");
endmodule
bind mst_stream_attr_regs mst_stream_attr_regs_props i_props (.mclk, .nrst, .regAddr,
	.regRd, .regRdata, .s2AttrValid, .s2TotalLines, .s2FirstMisc, .s2ClockRecM,
	.s2BlankIdValid, .s2BlankIdByte, .s3AttrValid, .s3ActivePixels);
`default_nettype wire

// [tb/attr_link_tx_model.sv]
`timescale 1ns/100ps
`default_nettype none
module attr_link_tx_model (
	input  wire logic         mclk,           // Clock
	output logic              s2AttrValid,    // S2 strobe
	output logic      [110:0] s2Fields,       // S2 words
	output logic              s2BlankIdValid, // Id strobe
	output logic      [7:0]   s2BlankIdByte,  // Id byte
	output logic              s3AttrValid,    // S3 strobe
	output logic      [127:0] s3Fields        // S3 words
);
	// Idle link at start
	initial begin
		{s3AttrValid, s2BlankIdValid, s2AttrValid} = 3'h0;
		{s3Fields, s2Fields, s2BlankIdByte} = '0;
	end
	// One-cycle frame; then fields flip, so sampling without a strobe shows
	task automatic send(input logic [2:0] g, input logic [127:0] f);
		@(posedge mclk);
		{s3AttrValid, s2BlankIdValid, s2AttrValid} <= g;
		s2Fields <= g[0] ? f[110:0] : s2Fields;
		s2BlankIdByte <= g[1] ? f[7:0] : s2BlankIdByte;
		s3Fields <= g[2] ? f : s3Fields;
		@(posedge mclk);
		{s3AttrValid, s2BlankIdValid, s2AttrValid} <= 3'h0;
		s2Fields <= g[0] ? ~f[110:0] : s2Fields;
		s2BlankIdByte <= g[1] ? ~f[7:0] : s2BlankIdByte;
		s3Fields <= g[2] ? ~f : s3Fields;
	endtask
endmodule
`default_nettype wire

// [tb/mst_stream_attr_regs_tb_top.sv]
`timescale 1ns/100ps
`default_nettype none
module mst_stream_attr_regs_tb_top;
	logic         mclk, nrst, regWr, regRd, s2AttrValid, s2BlankIdValid, s3AttrValid;
	logic         s3HsyncPolarity, s3VsyncPolarity;
	logic [11:0]  regAddr;
	logic [31:0]  regWdata, regRdata;
	logic [110:0] s2Fields;
	logic [127:0] s3Fields, f;
	logic [7:0]   s2BlankIdByte, s2FirstMisc, s2SecondMisc;
	logic [14:0]  s2VsyncWidth, s3HsyncWidth, s3VsyncWidth;
	logic [15:0]  s2VsyncToActive, s2TotalLines, s3ActivePixels, s3HsyncToActive;
	logic [15:0]  s3LineTotalClocks, s3ActiveLines, s3VsyncToActive, s3TotalLines;
	logic [23:0]  s2ClockRecM, s2ClockRecN;
	logic [31:0]  ev [18];
	int           nErrors, nChecks;
	int           ci [6] = '{8, 2, 5, 7, 4, 14};
	assign {s2VsyncWidth, s2VsyncToActive, s2TotalLines, s2FirstMisc, s2SecondMisc,
		s2ClockRecM, s2ClockRecN} = s2Fields;
	assign {s3ActivePixels, s3HsyncPolarity, s3HsyncWidth, s3HsyncToActive, s3LineTotalClocks,
		s3ActiveLines, s3VsyncPolarity, s3VsyncWidth, s3VsyncToActive, s3TotalLines} = s3Fields;
	attr_link_tx_model i_tx (.mclk, .s2AttrValid, .s2Fields, .s2BlankIdValid, .s2BlankIdByte,
		.s3AttrValid, .s3Fields);
	mst_stream_attr_regs i_dut (.*);
	always #12.5 mclk = ~mclk;
	function automatic logic [11:0] adr(input int i);
		return (i < 8) ? 12'h55c + 12'(4 * i) : 12'h580 + 12'(4 * (i - 8));
	endfunction
	// Expected words after a capture; second misc loses bits 6:3
	function automatic void upd(input logic [2:0] g, input logic [127:0] v);
		if (g[0])
			ev[0:6] = '{v[110:96], v[95:80], v[79:64], v[63:56], {v[55], 4'h0, v[50:48]},
				v[47:24], v[23:0]};
		if (g[1])
			ev[7] = {24'h0, v[7:0]};
		if (g[2])
			ev[8:17] = '{v[127:112], v[111], v[110:96], v[95:80], v[79:64], v[63:48], v[47],
				v[46:32], v[31:16], v[15:0]};
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		nChecks++;
		if (got !== exp) begin
			nErrors++;
			$display("unexpected at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask
	task automatic rd(input logic [11:0] a, output logic [31:0] d);
		@(posedge mclk);
		regRd <= 1'b1;
		regAddr <= a;
		@(posedge mclk);
		regRd <= 1'b0;
		#1 d = regRdata;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] v);
		@(posedge mclk);
		regWr <= 1'b1;
		regAddr <= a;
		regWdata <= v;
		@(posedge mclk);
		regWr <= 1'b0;
	endtask
	// Whole map plus the hole between the streams
	task automatic sweep();
		logic [31:0] d;
		for (int i = 0; i < 18; i++) begin
			rd(adr(i), d);
			chk(d, ev[i]);
		end
		rd(12'h57c, d);
		chk(d, mst_attr_pkg::UNMAPPED_READ);
	endtask
	// Read lands in the cycle right after the capture edge, the tightest case
	task automatic cap(input logic [2:0] g, input logic [127:0] v, input int i);
		logic [31:0] d;
		fork
			i_tx.send(g, v);
			begin
				@(posedge mclk);
				rd(adr(i), d);
			end
		join
		upd(g, v);
		chk(d, ev[i]);
	endtask
	task automatic testDone();
		$display("checks %0d, mismatches %0d", nChecks, nErrors);
		if (nErrors == 0 && nChecks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial begin
		{mclk, nrst, regWr, regRd, regAddr, regWdata} = '0;
		ev = '{default: mst_attr_pkg::ATTR_RESET};
		void'($urandom(32'h9739));
		repeat (5) @(posedge mclk);
		nrst <= 1'b1;
		sweep();
		$display("reset value test done");
		for (int c = 0; c < 4; c++) begin
			f = {$urandom, $urandom, $urandom, $urandom};
			f[58:57] = 2'(c);
			cap(3'h1, f, 3);
		end
		foreach (ci[k])
			cap(3'h7, {128{~k[0]}}, ci[k]);
		sweep();
		$display("corner capture test done");
		// Random groups, coinciding captures among them
		repeat (24) begin
			f = {$urandom, $urandom, $urandom, $urandom};
			cap(3'($urandom_range(1, 7)), f, $urandom_range(0, 17));
			sweep();
		end
		$display("random capture test done");
		for (int i = 0; i < 18; i++)
			wr(adr(i), $urandom);
		sweep();
		$display("write ignore test done");
		@(posedge mclk);
		nrst <= 1'b0;
		ev = '{default: mst_attr_pkg::ATTR_RESET};
		repeat (5) @(posedge mclk);
		nrst <= 1'b1;
		sweep();
		$display("mid-run reset test done");
		testDone();
	end
	// Run needs about 1200 cycles; this cuts a hang at 10000
	initial begin
		#(25 * 10000);
		nErrors++;
		testDone();
	end
endmodule
`default_nettype wire
